// ===== rtl/dac_ctl_regs.svh
// register offsets, field positions, reset values and update rates in Hz
`ifndef DAC_CTL_REGS_SVH
`define DAC_CTL_REGS_SVH

`define CTRL_INDEX        8'h55
`define DATA_INDEX        8'h01
`define RESET_INDEX       8'h56
`define STATUS_INDEX      8'h00
`define CODE_INDEX        8'h02
`define CTRL_ADDR         10'h154
`define DATA_ADDR         10'h004
`define RESET_ADDR        10'h158
`define STATUS_ADDR       10'h000
`define CODE_ADDR         10'h008

`define CTRL_RESET        16'h0000
`define DATA_RESET        16'h0000
`define RESET_BIT         0
`define STAT_OVERTEMP     0
`define STAT_SLEW_ACTIVE  1
`define STAT_LOOP_ERROR   2

`define RATE_HZ_0         257730
`define RATE_HZ_1         198410
`define RATE_HZ_2         152440
`define RATE_HZ_3         131580
`define RATE_HZ_4         115740
`define RATE_HZ_5         69440
`define RATE_HZ_6         37590
`define RATE_HZ_7         25770
`define RATE_HZ_8         20160
`define RATE_HZ_9         16030
`define RATE_HZ_10        10290
`define RATE_HZ_11        8280
`define RATE_HZ_12        6900
`define RATE_HZ_13        5530
`define RATE_HZ_14        4240
`define RATE_HZ_15        3300
`define CLK_HZ_DEFAULT    100000000

`endif

// ===== rtl/dac_ctl_pkg.sv
// types shared by the converter control blocks
package dac_ctl_pkg;

  typedef struct packed {
    logic [1:0] spare;
    logic       externalSenseResistorSel;
    logic       outputDriveOn;
    logic [3:0] slewUpdateRateSel;
    logic [2:0] slewIncrementSel;
    logic       slewLimitOn;
    logic       daisyChainOn;
    logic [2:0] rangeSel;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] count;
  } tick_state_t;

  typedef struct packed {
    logic [15:0] code;
  } step_state_t;

  typedef struct packed {
    ctrl_t       ctrl;
    logic [15:0] dataCode;
    logic [15:0] target;
    logic [15:0] preClear;
    logic        restoreArmed;
    logic        clearPrev;
    logic        latchPrevB;
    logic        haltReq;
    logic [31:0] rdata;
    logic        slvErr;
  } top_state_t;

endpackage : dac_ctl_pkg

// ===== rtl/slew_tick_gen.sv
// update-rate divider for the slew engine
`timescale 1ns/1ps
`include "dac_ctl_regs.svh"
module slew_tick_gen
  import dac_ctl_pkg::*;
#(
  parameter int CLK_HZ = `CLK_HZ_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [3:0] rateSel,
  output logic            tick
);

  // clock cycles per update; same table for every range
  function automatic logic [15:0] rateDivide(input logic [3:0] sel);
    int hz;
    hz = `RATE_HZ_0;
    unique case (sel)
      4'h0: hz = `RATE_HZ_0;
      4'h1: hz = `RATE_HZ_1;
      4'h2: hz = `RATE_HZ_2;
      4'h3: hz = `RATE_HZ_3;
      4'h4: hz = `RATE_HZ_4;
      4'h5: hz = `RATE_HZ_5;
      4'h6: hz = `RATE_HZ_6;
      4'h7: hz = `RATE_HZ_7;
      4'h8: hz = `RATE_HZ_8;
      4'h9: hz = `RATE_HZ_9;
      4'hA: hz = `RATE_HZ_10;
      4'hB: hz = `RATE_HZ_11;
      4'hC: hz = `RATE_HZ_12;
      4'hD: hz = `RATE_HZ_13;
      4'hE: hz = `RATE_HZ_14;
      4'hF: hz = `RATE_HZ_15;
    endcase
    if (CLK_HZ / hz < 1)
      return 16'h0001;
    return 16'(CLK_HZ / hz);
  endfunction : rateDivide

  tick_state_t st;
  tick_state_t stNext;

  always_comb
  begin
    stNext = st;
    if (!run)
      stNext.count = rateDivide(rateSel) - 16'h0001;
    else if (st.count == 16'h0000)
      stNext.count = rateDivide(rateSel) - 16'h0001;
    else
      stNext.count = st.count - 16'h0001;
  end

  assign tick = run && (st.count == 16'h0000);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else if (ce)
      st <= stNext;
  end

endmodule : slew_tick_gen

// ===== rtl/slew_stepper.sv
// holds the output code and steps it toward the target
`timescale 1ns/1ps
module slew_stepper
  import dac_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        slewOn,
  input  wire logic        tick,
  input  wire logic [2:0]  stepSel,
  input  wire logic [15:0] target,
  output logic [15:0]      code,
  output logic             active
);

  step_state_t st;
  step_state_t stNext;
  logic [16:0] stepSize;
  logic [16:0] distance;

  // step counts in 16-bit code units, so range does not change it
  assign stepSize = 17'h00001 << stepSel;

  always_comb
  begin
    stNext = st;
    distance = (target > st.code) ? {1'b0, target} - {1'b0, st.code}
                                  : {1'b0, st.code} - {1'b0, target};
    if (!slewOn)
      stNext.code = target;
    else if (tick && (st.code != target))
    begin
      // clamp so the last step lands exactly on target
      if (distance <= stepSize)
        stNext.code = target;
      else if (target > st.code)
        stNext.code = st.code + stepSize[15:0];
      else
        stNext.code = st.code - stepSize[15:0];
    end
  end

  assign code = st.code;
  assign active = slewOn && (st.code != target);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else if (ce)
      st <= stNext;
  end

endmodule : slew_stepper

// ===== rtl/dac_slew_and_clear_control.sv
// output-code control: clear, restore, slew engine and APB registers
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dac_ctl_regs.svh"
module dac_slew_and_clear_control
  import dac_ctl_pkg::*;
#(
  parameter int RESOLUTION = 16,
  parameter int CLK_HZ     = `CLK_HZ_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clearIn,
  input  wire logic        latchStrobeB,
  input  wire logic        loopErrorIn,
  input  wire logic        overTempIn,
  input  wire logic        modulationIn,
  output logic             modulationOut,
  output logic             faultOut,
  output logic             faultOe,
  output logic [15:0]      dacCode,
  output logic             outputDriveOn,
  output logic             externalSenseResistorSel,
  output logic [2:0]       rangeSel
);

  // low bits below the converter's resolution are dropped on data writes
  function automatic logic [15:0] codeMask(input logic [15:0] value);
    logic [15:0] mask;
    mask = 16'hFFFF << (16 - RESOLUTION);
    return value & mask;
  endfunction : codeMask

  top_state_t st;
  top_state_t stNext;
  logic        tick;
  logic        stepTick;
  logic        ctrlWrite;
  logic [15:0] code;
  logic        slewActive;
  logic        setupPhase;
  logic        accessWrite;
  logic        clearRise;
  logic        latchFall;
  logic [15:0] statusWord;

  assign setupPhase  = psel && !penable;
  assign accessWrite = psel && penable && pwrite && ce;
  assign ctrlWrite   = accessWrite && (paddr == `CTRL_ADDR);
  // no step on the halting edge, so the frozen code is the one shown
  // and the ramp cannot overshoot and walk back
  assign stepTick    = tick && !ctrlWrite;
  assign clearRise   = clearIn && !st.clearPrev;
  assign latchFall   = !latchStrobeB && st.latchPrevB;

  // separate bits tell which cause pulled the shared fault pin
  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[`STAT_OVERTEMP]    = overTempIn;
    statusWord[`STAT_SLEW_ACTIVE] = slewActive;
    statusWord[`STAT_LOOP_ERROR]  = loopErrorIn;
  end

  always_comb
  begin
    stNext = st;
    stNext.clearPrev  = clearIn;
    stNext.latchPrevB = latchStrobeB;
    stNext.haltReq    = 1'b0;

    // the halt set at the control write is applied again one cycle later, when the
    // stepper code is known to be stable for that write
    if (st.haltReq)
      stNext.target = code;

    // clear: catch the code to restore, then aim at range bottom
    if (clearRise)
    begin
      stNext.preClear     = st.dataCode;
      stNext.restoreArmed = 1'b1;
      stNext.target       = 16'h0000;
    end
    else if (latchFall && !clearIn && st.restoreArmed)
    begin
      // restore only when no fresh code has been written since
      stNext.target       = st.preClear;
      stNext.dataCode     = st.preClear;
      stNext.restoreArmed = 1'b0;
    end
    // otherwise nothing returns the code on its own

    // register reads are captured in the setup phase
    if (setupPhase)
    begin
      stNext.rdata  = 32'h0000_0000;
      stNext.slvErr = 1'b0;
      unique case (paddr)
        `CTRL_ADDR:   stNext.rdata = {16'h0000, st.ctrl};
        `DATA_ADDR:   stNext.rdata = {16'h0000, st.dataCode};
        `STATUS_ADDR: stNext.rdata = {16'h0000, statusWord};
        `CODE_ADDR:   stNext.rdata = {16'h0000, code};
        `RESET_ADDR:  stNext.rdata = 32'h0000_0000;
        default:      stNext.slvErr = 1'b1;
      endcase
    end

    if (accessWrite)
    begin
      unique case (paddr)
        `CTRL_ADDR:
        begin
          // writing slew and range settings
          stNext.ctrl       = ctrl_t'(pwdata[15:0]);
          stNext.ctrl.spare = 2'b00;
          stNext.target     = code;
          stNext.haltReq    = 1'b1;
        end
        `DATA_ADDR:
        begin
          // a code written under clear is dropped
          if (!clearIn && !clearRise)
          begin
            stNext.dataCode     = codeMask(pwdata[15:0]);
            stNext.target       = codeMask(pwdata[15:0]);
            stNext.restoreArmed = 1'b0;
          end
        end
        `RESET_ADDR:
        begin
          if (pwdata[`RESET_BIT])
          begin
            stNext.ctrl         = ctrl_t'(`CTRL_RESET);
            stNext.dataCode     = `DATA_RESET;
            stNext.target       = `DATA_RESET;
            stNext.preClear     = `DATA_RESET;
            stNext.restoreArmed = 1'b0;
            stNext.haltReq      = 1'b0;
          end
        end
        default:
        begin
          stNext.slvErr = st.slvErr;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st            <= '0;
      st.latchPrevB <= 1'b1;
    end
    else if (ce)
      st <= stNext;
  end

  slew_tick_gen #(
    .CLK_HZ (CLK_HZ)
  ) tickGen (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .run     (slewActive),
    .rateSel (st.ctrl.slewUpdateRateSel),
    .tick    (tick)
  );

  slew_stepper stepper (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .slewOn  (st.ctrl.slewLimitOn),
    .tick    (stepTick),
    .stepSel (st.ctrl.slewIncrementSel),
    .target  (st.target),
    .code    (code),
    .active  (slewActive)
  );

  // pready drops with ce so a frozen block never accepts a transfer
  assign pready  = ce;
  assign prdata  = st.rdata;
  assign pslverr = st.slvErr && psel && penable;

  assign dacCode                  = code;
  assign outputDriveOn            = st.ctrl.outputDriveOn;
  assign externalSenseResistorSel = st.ctrl.externalSenseResistorSel;
  assign rangeSel                 = st.ctrl.rangeSel;
  assign modulationOut = modulationIn && st.ctrl.outputDriveOn;

  // open-drain fault pin: pulled low while either cause is present
  assign faultOut = 1'b0;
  assign faultOe  = loopErrorIn || overTempIn;

endmodule : dac_slew_and_clear_control

// ===== test/dac_ctl_monitor.sv
// assertions on the converter control block ports
`timescale 1ns/1ps
`include "dac_ctl_regs.svh"
module dac_ctl_monitor
  import dac_ctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        clearIn,
  input wire logic        modulationIn,
  input wire logic        modulationOut,
  input wire logic [15:0] dacCode,
  input wire logic        outputDriveOn,
  input wire logic [2:0]  rangeSel
);
  logic slewOn_reg;
  wire  wrCtrl = psel && penable && pwrite && paddr == `CTRL_ADDR;
  wire  wrData = psel && penable && pwrite && paddr == `DATA_ADDR;
  // mirror of the slew bit, to tell slewed moves from direct loads
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      slewOn_reg <= 1'b0;
    else if (wrCtrl)
      slewOn_reg <= pwdata[4];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_move;
    slewOn_reg && $past(slewOn_reg) && dacCode != $past(dacCode);
  endsequence
  sequence s_load;
    wrData && !clearIn && !$past(clearIn) && !slewOn_reg;
  endsequence
  chk_mod_gate:
    assert property (modulationOut == (modulationIn && outputDriveOn))
      else $error("mod gate");
  chk_clear_down:
    assert property (clearIn && $past(clearIn, 2)
      |-> dacCode <= $past(dacCode)) else $error("rose in clear");
  chk_clear_hold:
    assert property ($fell(clearIn) && dacCode == 16'h0000
      |=> dacCode == 16'h0000) else $error("left clear");
  chk_direct_load:
    assert property (s_load |-> ##2 dacCode == $past(pwdata[15:0], 2))
      else $error("no direct load");
  chk_ctrl_fields:
    assert property (wrCtrl |=> rangeSel == $past(pwdata[2:0])
      && outputDriveOn == $past(pwdata[12])) else $error("ctrl fields");
  chk_slew_step:
    assert property (s_move |-> dacCode - $past(dacCode) <= 16'h0080
      || $past(dacCode) - dacCode <= 16'h0080) else $error("big step");
  chk_slew_pace:
    assert property (s_move |=> $stable(dacCode))
      else $error("steps adjacent");
  chk_halt_stop:
    assert property (wrCtrl |-> ##4 $stable(dacCode) [*4])
      else $error("ramp ran on");
endmodule : dac_ctl_monitor

bind dac_slew_and_clear_control dac_ctl_monitor u_mon (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .clearIn,
  .modulationIn, .modulationOut, .dacCode, .outputDriveOn, .rangeSel
);

// ===== test/host_pin_model.sv
// host-side model of the clear, latch, fault and modulation pins
`timescale 1ns/1ps
module host_pin_model
(
  input  wire logic clk,
  output logic      clearIn = 1'b0,
  output logic      latchStrobeB = 1'b1,
  output logic      loopErrorIn = 1'b0,
  output logic      overTempIn = 1'b0,
  output logic      modulationIn = 1'b0
);
  // tone flips every cycle so both gate states are seen
  always @(posedge clk)
    modulationIn <= ~modulationIn;
  task clear_on();
    @(posedge clk);
    clearIn <= 1'b1;
  endtask : clear_on
  // n must stay above the minimum clear time
  task clear_off(input int n);
    repeat (n) @(posedge clk);
    clearIn <= 1'b0;
  endtask : clear_off
  task latch_pulse();
    @(posedge clk);
    latchStrobeB <= 1'b0;
    @(posedge clk);
    latchStrobeB <= 1'b1;
  endtask : latch_pulse
  task faults(input logic loop, input logic hot);
    @(posedge clk);
    loopErrorIn <= loop;
    overTempIn <= hot;
  endtask : faults
endmodule : host_pin_model

// ===== test/test_dac_slew_and_clear_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "dac_ctl_regs.svh"
module test_dac_slew_and_clear_control import dac_ctl_pkg::*;;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, want = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdVal;
  logic        pready, pslverr, modulationOut, faultOut, faultOe;
  logic        outputDriveOn, externalSenseResistorSel;
  logic        clearIn, latchStrobeB, loopErrorIn, overTempIn, modulationIn;
  logic [15:0] dacCode, v;
  logic [2:0]  rangeSel;
  logic [32:0] expQ[$];
  int          seed = 96692, fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  host_pin_model u_host (.clk, .clearIn, .latchStrobeB, .loopErrorIn,
    .overTempIn, .modulationIn);
  dac_slew_and_clear_control #(.RESOLUTION(16), .CLK_HZ(1000000)) u_dut (
    .clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clearIn, .latchStrobeB, .loopErrorIn, .overTempIn,
    .modulationIn, .modulationOut, .faultOut, .faultOe, .dacCode,
    .outputDriveOn, .externalSenseResistorSel, .rangeSel);
  task test_done();
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task bad(input string m);
    fail_count++;
    $display("mismatch %0t %s", $time, m);
  endtask : bad
  task compare(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
      bad("read data");
  endtask : compare
  task compare_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
      bad("pin level");
  endtask : compare_pin
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d,
           input logic c);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    want <= c;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad("no ready");
      test_done();
    end
    rdVal = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    want <= 1'b0;
    // a control write halts ramps, so let it settle first
    if (w && a == `CTRL_ADDR)
      repeat (6) @(posedge clk);
  endtask : apb
  task wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr
  task rd(input logic [9:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask : rd
  task poll();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `STATUS_ADDR, 32'h0, 1'b0);
      k++;
    end
    while (rdVal[1] !== 1'b0 && k < 900);
    if (k >= 900)
    begin
      bad("ramp hung");
      test_done();
    end
  endtask : poll
  always @(posedge clk)
    if (psel && penable && pready && !pwrite && want)
      compare({pslverr, prdata}, expQ.pop_front());
  initial
  begin
    repeat (90000) @(posedge clk);
    bad("timeout");
    test_done();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(`CTRL_ADDR, 33'h0);
    rd(10'h00C, {1'b1, 32'h0});
    v = 16'($random(seed));
    wr(`CTRL_ADDR, {18'h0, v[13:5], 1'b0, v[3:0]});
    rd(`CTRL_ADDR, {19'h0, v[13:5], 1'b0, v[3:0]});
    compare_pin(externalSenseResistorSel, v[13]);
    compare_pin(outputDriveOn, v[12]);
    v = 16'($random(seed));
    wr(`DATA_ADDR, {16'h0, v});
    rd(`CODE_ADDR, {17'h0, v});
    u_host.faults(1'b1, 1'b0);
    rd(`STATUS_ADDR, 33'h4);
    compare_pin(faultOe, 1'b1);
    u_host.faults(1'b0, 1'b1);
    rd(`STATUS_ADDR, 33'h1);
    compare_pin(faultOe, 1'b1);
    u_host.faults(1'b0, 1'b0);
    @(posedge clk);
    compare_pin(faultOe, 1'b0);
    compare_pin(faultOut, 1'b0);
    u_host.clear_on();
    wr(`DATA_ADDR, {16'h0, ~v});
    rd(`CODE_ADDR, 33'h0);
    u_host.clear_off(2);
    rd(`CODE_ADDR, 33'h0);
    u_host.clear_on();
    u_host.clear_off(4);
    u_host.latch_pulse();
    rd(`CODE_ADDR, {17'h0, v});
    wr(`RESET_ADDR, 32'h1);
    rd(`CTRL_ADDR, 33'h0);
    wr(`DATA_ADDR, 32'h0);
    wr(`CTRL_ADDR, 32'hF0);
    wr(`DATA_ADDR, 32'h450);
    rd(`STATUS_ADDR, 33'h2);
    poll();
    rd(`CODE_ADDR, 33'h450);
    u_host.clear_on();
    repeat (3) @(posedge clk);
    rd(`STATUS_ADDR, 33'h2);
    poll();
    rd(`CODE_ADDR, 33'h0);
    u_host.clear_off(1);
    wr(`CTRL_ADDR, 32'h10);
    wr(`DATA_ADDR, 32'h100);
    repeat (30) @(posedge clk);
    wr(`CTRL_ADDR, 32'h10);
    rd(`STATUS_ADDR, 33'h0);
    test_done();
  end
endmodule : test_dac_slew_and_clear_control
